// ==== src/tdc_capture.sv ====
// How it works
// R1 - software loads both count-load registers with all-ones before it turns demodulation on.
// R2 - once enabled the counter waits idle until the first edge of the selected polarity, then counts down.
// R3 - a later qualifying edge while counting stores the inverted counter value into a capture register.
// R4 - rising-edge captures go to the low-interval register, falling-edge captures to the high-interval one.
// R5 - each capture sets its rising or falling flag and requests an interrupt when capture interrupts are on.
// R6 - a capture also reloads the counter with all-ones and counting resumes from there.
// R7 - reaching zero sets the time-out flag, requests an interrupt if enabled, and counting goes on from all-ones.
// R8 - the high-interval capture register is eight bits of time-at-one and ignores writes.
// R9 - the low-interval capture register is eight bits of time-at-zero and ignores writes.
// R10 - edge-select 00 is falling, 01 rising, 10 both, and 11 is reserved and qualifies nothing.
// R11 - edge flags read as set after an edge, writing one clears them and writing zero keeps them.
// R12 - the input-select bit routes the port 3 line (0) or the port 2 line (1) to the edge detector.
// R13 - the filter field picks no filter, a 4-cycle or an 8-cycle glitch filter, with 11 reserved.
// R14 - the input is synchronised to the clock before edge detection so each edge gives one event.
// R15 - a capture in the same cycle as reaching zero wins, and the counter restarts from all-ones.
module tdc_capture
   import tdc_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // demodulator pins
   input wire logic port3_line1_input,
   input wire logic port2_line0_input,
   // interrupt requests
   output logic capture_irq,
   output logic timeout_irq
);

   tdc_ctl0_t ctl0_ff, nxt_ctl0;
   tdc_ctl1_t ctl1_ff, nxt_ctl1;
   logic [7:0] load_lo_ff, nxt_load_lo;
   logic [7:0] load_hi_ff, nxt_load_hi;
   logic [7:0] cap_lo_ff, nxt_cap_lo;
   logic [7:0] cap_hi_ff, nxt_cap_hi;
   logic [7:0] count_ff, nxt_count;
   tdc_state_t state_ff, nxt_state;
   logic [31:0] prdata_ff, nxt_prdata;
   logic level;
   logic level_prev_ff;
   logic run;
   logic rise, fall;
   logic qual_rise, qual_fall, qual;
   logic cap_rise, cap_fall, capture;
   logic reach_zero, timeout_set;
   logic wr, setup, mapped;
   logic wr_ctl0, wr_ctl1;

   // true when the bus address hits the register at this index
   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] idx);
      hit = (addr == ADDR_W'({idx, 2'b00}));
   endfunction

   // synchronised, selected and filtered input
   tdc_in_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .port3_line1_input(port3_line1_input),
      .port2_line0_input(port2_line0_input),
      .input_sel(ctl1_ff.input_sel),
      .filter_sel(ctl1_ff.filter_sel),
      .level_ff(level)
   ); // R14

   // bus decode; the slave answers in the first access cycle
   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && pwrite;
      mapped = hit(paddr, TDC_IDX_CTL0) || hit(paddr, TDC_IDX_CTL1) || hit(paddr, TDC_IDX_LOAD_LO)
         || hit(paddr, TDC_IDX_LOAD_HI) || hit(paddr, TDC_IDX_CAP_LO) || hit(paddr, TDC_IDX_CAP_HI);
      wr_ctl0 = wr && hit(paddr, TDC_IDX_CTL0);
      wr_ctl1 = wr && hit(paddr, TDC_IDX_CTL1);
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_ff;

   // edge detection and qualification
   always_comb begin
      run = ctl0_ff.enable && ctl1_ff.mode_demod;
      rise = level && !level_prev_ff; // R14
      fall = !level && level_prev_ff; // R14
      qual_rise = rise && (ctl1_ff.edge_sel == TDC_EDGE_RISE || ctl1_ff.edge_sel == TDC_EDGE_BOTH); // R10
      qual_fall = fall && (ctl1_ff.edge_sel == TDC_EDGE_FALL || ctl1_ff.edge_sel == TDC_EDGE_BOTH); // R10
      qual = qual_rise || qual_fall;
      cap_rise = run && (state_ff == TDC_ST_COUNT) && qual_rise;
      cap_fall = run && (state_ff == TDC_ST_COUNT) && qual_fall;
      capture = cap_rise || cap_fall;
      reach_zero = run && (state_ff == TDC_ST_COUNT) && (count_ff == 8'h00);
      timeout_set = reach_zero && !capture; // R15
   end

   // counter state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      if (!run) begin
         nxt_state = TDC_ST_IDLE;
         nxt_count = TDC_RELOAD;
      end else begin
         case (state_ff)
            TDC_ST_IDLE: begin
               if (qual) begin
                  nxt_state = TDC_ST_COUNT; // R2
                  nxt_count = TDC_RELOAD;
               end
            end
            TDC_ST_COUNT: begin
               if (capture) begin
                  nxt_count = TDC_RELOAD; // R6 R15
               end else if (reach_zero) begin
                  nxt_count = TDC_RELOAD; // R7
               end else begin
                  nxt_count = count_ff - 8'h01; // R2
               end
            end
            default: begin
               nxt_state = TDC_ST_IDLE;
               nxt_count = TDC_RELOAD;
            end
         endcase
      end
   end

   // capture registers ignore bus writes
   always_comb begin
      nxt_cap_lo = cap_lo_ff;
      nxt_cap_hi = cap_hi_ff;
      if (cap_rise) begin
         nxt_cap_lo = ~count_ff; // R3 R4 R9
      end
      if (cap_fall) begin
         nxt_cap_hi = ~count_ff; // R3 R4 R8
      end
   end

   // software registers; hardware set wins over a write-one clear
   always_comb begin
      nxt_ctl0 = ctl0_ff;
      nxt_ctl1 = ctl1_ff;
      nxt_load_lo = load_lo_ff;
      nxt_load_hi = load_hi_ff;
      if (wr_ctl0) begin
         nxt_ctl0 = tdc_ctl0_t'(pwdata[7:0]);
         nxt_ctl0.timeout_flag = ctl0_ff.timeout_flag && !pwdata[TDC_TO_FLAG_BIT];
      end
      if (wr_ctl1) begin
         nxt_ctl1 = tdc_ctl1_t'(pwdata[7:0]);
         nxt_ctl1.fall_flag = ctl1_ff.fall_flag && !pwdata[TDC_FALL_FLAG_BIT]; // R11
         nxt_ctl1.rise_flag = ctl1_ff.rise_flag && !pwdata[TDC_RISE_FLAG_BIT]; // R11
      end
      if (wr && hit(paddr, TDC_IDX_LOAD_LO)) begin
         nxt_load_lo = pwdata[7:0];
      end
      if (wr && hit(paddr, TDC_IDX_LOAD_HI)) begin
         nxt_load_hi = pwdata[7:0];
      end
      if (timeout_set) begin
         nxt_ctl0.timeout_flag = 1'b1; // R7
      end
      if (cap_rise) begin
         nxt_ctl1.rise_flag = 1'b1; // R5
      end
      if (cap_fall) begin
         nxt_ctl1.fall_flag = 1'b1; // R5
      end
   end

   // read data is latched in the setup cycle
   always_comb begin
      nxt_prdata = prdata_ff;
      if (setup) begin
         nxt_prdata = 32'h0;
         if (hit(paddr, TDC_IDX_CTL0)) begin
            nxt_prdata[7:0] = ctl0_ff;
         end else if (hit(paddr, TDC_IDX_CTL1)) begin
            nxt_prdata[7:0] = ctl1_ff; // R11
         end else if (hit(paddr, TDC_IDX_LOAD_LO)) begin
            nxt_prdata[7:0] = load_lo_ff;
         end else if (hit(paddr, TDC_IDX_LOAD_HI)) begin
            nxt_prdata[7:0] = load_hi_ff;
         end else if (hit(paddr, TDC_IDX_CAP_LO)) begin
            nxt_prdata[7:0] = cap_lo_ff; // R9
         end else if (hit(paddr, TDC_IDX_CAP_HI)) begin
            nxt_prdata[7:0] = cap_hi_ff; // R8
         end
      end
   end

   // interrupt requests follow flag and enable
   assign capture_irq = ctl0_ff.cap_irq_en && (ctl1_ff.rise_flag || ctl1_ff.fall_flag); // R5
   assign timeout_irq = ctl0_ff.to_irq_en && ctl0_ff.timeout_flag; // R7

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0_ff <= tdc_ctl0_t'(TDC_CTL0_RST);
         ctl1_ff <= tdc_ctl1_t'(TDC_CTL1_RST);
         load_lo_ff <= TDC_LOAD_RST;
         load_hi_ff <= TDC_LOAD_RST;
         cap_lo_ff <= TDC_CAP_RST;
         cap_hi_ff <= TDC_CAP_RST;
         count_ff <= TDC_RELOAD;
         state_ff <= TDC_ST_IDLE;
         prdata_ff <= 32'h0;
         level_prev_ff <= 1'b0;
      end else begin
         ctl0_ff <= nxt_ctl0;
         ctl1_ff <= nxt_ctl1;
         load_lo_ff <= nxt_load_lo;
         load_hi_ff <= nxt_load_hi;
         cap_lo_ff <= nxt_cap_lo;
         cap_hi_ff <= nxt_cap_hi;
         count_ff <= nxt_count;
         state_ff <= nxt_state;
         prdata_ff <= nxt_prdata;
         level_prev_ff <= level;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_counting;
      run && state_ff == TDC_ST_COUNT;
   endsequence

   sequence s_reloaded;
      count_ff == TDC_RELOAD;
   endsequence

   property p_idle_wait;
      run && state_ff == TDC_ST_IDLE && !qual |=> state_ff == TDC_ST_IDLE && count_ff == TDC_RELOAD;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("counter left idle without an edge"); // R2

   property p_start;
      run && state_ff == TDC_ST_IDLE && qual ##1 run && !qual |-> state_ff == TDC_ST_COUNT ##1 count_ff == 8'hfe;
   endproperty
   a_start: assert property (p_start) else $error("counter did not start on first edge"); // R2

   property p_cap_low;
      s_counting and qual_rise |=> cap_lo_ff == ~$past(count_ff) && ctl1_ff.rise_flag;
   endproperty
   a_cap_low: assert property (p_cap_low) else $error("rising capture wrong"); // R3 R4 R5

   property p_cap_high;
      s_counting and qual_fall |=> cap_hi_ff == ~$past(count_ff) && ctl1_ff.fall_flag;
   endproperty
   a_cap_high: assert property (p_cap_high) else $error("falling capture wrong"); // R3 R4 R5

   property p_reload;
      capture |=> s_reloaded;
   endproperty
   a_reload: assert property (p_reload) else $error("no reload after capture"); // R6

   property p_timeout;
      s_counting and (count_ff == 8'h00) and !capture |=> ctl0_ff.timeout_flag ##0 s_reloaded;
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out handling wrong"); // R7

   property p_priority;
      capture && reach_zero && !ctl0_ff.timeout_flag && !wr_ctl0 |=> !ctl0_ff.timeout_flag && count_ff == TDC_RELOAD;
   endproperty
   a_priority: assert property (p_priority) else $error("zero won over capture"); // R15

   property p_cap_ro;
      wr && hit(paddr, TDC_IDX_CAP_HI) && !cap_fall |=> $stable(cap_hi_ff);
   endproperty
   a_cap_ro: assert property (p_cap_ro) else $error("high capture took a write"); // R8

   property p_cap_lo_ro;
      wr && hit(paddr, TDC_IDX_CAP_LO) && !cap_rise |=> $stable(cap_lo_ff);
   endproperty
   a_cap_lo_ro: assert property (p_cap_lo_ro) else $error("low capture took a write"); // R9

   property p_w1c;
      wr_ctl1 && pwdata[TDC_RISE_FLAG_BIT] && !cap_rise |=> !ctl1_ff.rise_flag;
   endproperty
   a_w1c: assert property (p_w1c) else $error("rise flag not cleared"); // R11

   property p_reserved_edge;
      ctl1_ff.edge_sel == 2'h3 |-> !qual;
   endproperty
   a_reserved_edge: assert property (p_reserved_edge) else $error("reserved edge code qualified"); // R10

   property p_irq;
      ctl1_ff.rise_flag && ctl0_ff.cap_irq_en |-> capture_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("capture interrupt missing"); // R5

   sequence s_idle;
      run && state_ff == TDC_ST_IDLE;
   endsequence

   property p_first_no_cap;
      s_idle and qual |=> $stable(cap_lo_ff) && $stable(cap_hi_ff);
   endproperty
   a_first_no_cap: assert property (p_first_no_cap) else $error("first edge stored a capture"); // R2

   property p_disabled;
      !run |=> state_ff == TDC_ST_IDLE && count_ff == TDC_RELOAD;
   endproperty
   a_disabled: assert property (p_disabled) else $error("counter active while disabled"); // R2

   property p_count_down;
      s_counting and !capture and (count_ff != 8'h00) |=> count_ff == $past(count_ff) - 8'h01;
   endproperty
   a_count_down: assert property (p_count_down) else $error("counter did not step down"); // R2

   property p_fall_w1c;
      wr_ctl1 && pwdata[TDC_FALL_FLAG_BIT] && !cap_fall |=> !ctl1_ff.fall_flag;
   endproperty
   a_fall_w1c: assert property (p_fall_w1c) else $error("fall flag not cleared"); // R11

   property p_rise_keep;
      wr_ctl1 && !pwdata[TDC_RISE_FLAG_BIT] && ctl1_ff.rise_flag |=> ctl1_ff.rise_flag;
   endproperty
   a_rise_keep: assert property (p_rise_keep) else $error("rise flag lost on a zero write"); // R11

   property p_to_keep;
      ctl0_ff.timeout_flag && !(wr_ctl0 && pwdata[TDC_TO_FLAG_BIT]) |=> ctl0_ff.timeout_flag;
   endproperty
   a_to_keep: assert property (p_to_keep) else $error("time-out flag lost"); // R7

   property p_to_w1c;
      wr_ctl0 && pwdata[TDC_TO_FLAG_BIT] && !timeout_set |=> !ctl0_ff.timeout_flag;
   endproperty
   a_to_w1c: assert property (p_to_w1c) else $error("time-out flag not cleared"); // R7

   property p_to_irq;
      ctl0_ff.timeout_flag && ctl0_ff.to_irq_en |-> timeout_irq;
   endproperty
   a_to_irq: assert property (p_to_irq) else $error("time-out interrupt missing"); // R7

   property p_fall_irq;
      ctl1_ff.fall_flag && ctl0_ff.cap_irq_en |-> capture_irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("capture interrupt missing on fall"); // R5

endmodule

// ==== src/tdc_in_filter.sv ====
module tdc_in_filter
   import tdc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // raw pins
   input wire logic port3_line1_input,
   input wire logic port2_line0_input,
   // selection
   input wire logic input_sel,
   input wire logic [1:0] filter_sel,
   // conditioned level
   output logic level_ff
);

   logic [1:0] sync1_ff;
   logic [1:0] sync2_ff;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic nxt_level;
   logic pick;
   logic [3:0] need;

   // two-stage synchroniser on both pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 2'h0;
         sync2_ff <= 2'h0;
      end else begin
         sync1_ff <= {port2_line0_input, port3_line1_input};
         sync2_ff <= sync1_ff;
      end
   end

   // input select and glitch filter
   always_comb begin
      pick = input_sel ? sync2_ff[1] : sync2_ff[0]; // R12
      need = (filter_sel == TDC_FILT_8) ? TDC_FILT8_CYC : TDC_FILT4_CYC; // R13
      nxt_cnt = 4'h0;
      nxt_level = level_ff;
      if (filter_sel == TDC_FILT_4 || filter_sel == TDC_FILT_8) begin
         if (pick != level_ff) begin
            if (cnt_ff + 4'h1 >= need) begin
               nxt_level = pick; // R13
            end else begin
               nxt_cnt = cnt_ff + 4'h1;
            end
         end
      end else begin
         nxt_level = pick;
      end
   end

   // filter state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 4'h0;
         level_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         level_ff <= nxt_level;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_filter_hold;
      (filter_sel == TDC_FILT_8) && (pick != level_ff) && (cnt_ff < 4'h7) |=> $stable(level_ff);
   endproperty
   a_filter_hold: assert property (p_filter_hold) else $error("filtered level moved too early"); // R13

   property p_no_filter;
      (filter_sel == TDC_FILT_NONE) |=> level_ff == $past(pick);
   endproperty
   a_no_filter: assert property (p_no_filter) else $error("unfiltered level did not follow input"); // R13

endmodule

// ==== src/tdc_pkg.sv ====
package tdc_pkg;

   // register indices; byte address is four times the index
   localparam logic [3:0] TDC_IDX_CTL0 = 4'h0;
   localparam logic [3:0] TDC_IDX_CTL1 = 4'h1;
   localparam logic [3:0] TDC_IDX_LOAD_LO = 4'h4;
   localparam logic [3:0] TDC_IDX_LOAD_HI = 4'h5;
   localparam logic [3:0] TDC_IDX_CAP_LO = 4'ha;
   localparam logic [3:0] TDC_IDX_CAP_HI = 4'hb;

   // values after reset
   localparam logic [7:0] TDC_CTL0_RST = 8'h00;
   localparam logic [7:0] TDC_CTL1_RST = 8'h00;
   localparam logic [7:0] TDC_LOAD_RST = 8'h00;
   localparam logic [7:0] TDC_CAP_RST = 8'h00;
   localparam logic [7:0] TDC_RELOAD = 8'hff;

   // bit positions of the write-one-to-clear flags
   localparam int unsigned TDC_TO_FLAG_BIT = 5;
   localparam int unsigned TDC_FALL_FLAG_BIT = 1;
   localparam int unsigned TDC_RISE_FLAG_BIT = 0;

   // edge-select codes
   localparam logic [1:0] TDC_EDGE_FALL = 2'h0;
   localparam logic [1:0] TDC_EDGE_RISE = 2'h1;
   localparam logic [1:0] TDC_EDGE_BOTH = 2'h2;

   // glitch-filter codes and their lengths in clock cycles
   localparam logic [1:0] TDC_FILT_NONE = 2'h0;
   localparam logic [1:0] TDC_FILT_4 = 2'h1;
   localparam logic [1:0] TDC_FILT_8 = 2'h2;
   localparam logic [3:0] TDC_FILT4_CYC = 4'h4;
   localparam logic [3:0] TDC_FILT8_CYC = 4'h8;

   // control register zero layout
   typedef struct packed {
      logic enable;
      logic spare6;
      logic timeout_flag;
      logic [1:0] spare43;
      logic cap_irq_en;
      logic to_irq_en;
      logic spare0;
   } tdc_ctl0_t;

   // shared control register layout in demodulation mode
   typedef struct packed {
      logic mode_demod;
      logic input_sel;
      logic [1:0] edge_sel;
      logic [1:0] filter_sel;
      logic fall_flag;
      logic rise_flag;
   } tdc_ctl1_t;

   // counter states
   typedef enum logic [1:0] {
      TDC_ST_IDLE = 2'b01,
      TDC_ST_COUNT = 2'b10
   } tdc_state_t;

endpackage

// ==== tb/tdc_pulse_model.sv ====
// far side: a pulse source that drives the selected demodulator pin
module tdc_pulse_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pulse request
   input wire logic start,
   input wire logic route_p2,
   input wire logic [7:0] hi_len,
   input wire logic [7:0] lo_len,
   // pins and status
   output logic port3_line1_input,
   output logic port2_line0_input,
   output logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pulse;
   logic noise;
   // the unselected pin toggles every cycle so a wrong route shows up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         noise <= 1'b0;
      end else begin
         noise <= ~noise;
      end
   end
   // three whole periods, starting and ending low, so no edge is cut short
   initial begin
      pulse = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge pclk);
         if (start === 1'b1) begin
            busy <= 1'b1;
            repeat (3) begin
               pulse <= 1'b1;
               repeat (hi_len) @(posedge pclk);
               pulse <= 1'b0;
               repeat (lo_len) @(posedge pclk);
            end
            busy <= 1'b0;
         end
      end
   end
   // route the pulse to one pin and noise to the other
   assign port3_line1_input = route_p2 ? noise : pulse;
   assign port2_line0_input = route_p2 ? pulse : noise;
endmodule

// ==== tb/timer8_demodulation_capture_bench.sv ====
// register-level bench: apb tasks, pulse trains, expected captures
module timer8_demodulation_capture_bench import tdc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic p3, p2, capture_irq, timeout_irq, start, route_p2, busy, er;
   logic [7:0] hi_len, lo_len;
   int failures, checked, n;
   // case table: shared control, pulse lengths, expected captures and flags
   logic [7:0] cfg [6] = '{8'h90, 8'hc0, 8'ha4, 8'he8, 8'hb0, 8'h80};
   logic [7:0] hl [6] = '{8'h0a, 8'h0c, 8'h07, 8'h10, 8'h05, 8'h80};
   logic [7:0] ll [6] = '{8'h14, 8'h16, 8'h0f, 8'h09, 8'h05, 8'h80};
   logic [7:0] elo [6] = '{8'h1d, 8'h1d, 8'h0e, 8'h08, 8'h08, 8'h08};
   logic [7:0] ehi [6] = '{8'h00, 8'h21, 8'h06, 8'h0f, 8'h0f, 8'hff};
   logic [7:0] efl [6] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h00, 8'h02};

   tdc_capture i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port3_line1_input(p3), .port2_line0_input(p2), .capture_irq(capture_irq), .timeout_irq(timeout_irq));
   tdc_pulse_model i_src (.pclk(pclk), .presetn(presetn), .start(start), .route_p2(route_p2),
      .hi_len(hi_len), .lo_len(lo_len), .port3_line1_input(p3), .port2_line0_input(p2), .busy(busy));

   // clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // report counts and verdict, then stop
   task automatic finish_test;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // compare one value
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         failures++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read a register and compare its low byte with zero upper bits
   task automatic rchk(input logic [3:0] idx, input logic [7:0] exp, input string what);
      apb(1'b0, idx, 8'h00);
      check(rd, {24'h0, exp}, what);
   endtask

   initial begin
      {psel, penable, pwrite, start, route_p2} = '0;
      paddr = '0;
      pwdata = '0;
      hi_len = 8'h01;
      lo_len = 8'h01;
      failures = 0;
      checked = 0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // values after reset and refusal of an unmapped place
      rchk(TDC_IDX_CTL0, TDC_CTL0_RST, "ctl0 reset");
      rchk(TDC_IDX_CTL1, TDC_CTL1_RST, "ctl1 reset");
      rchk(TDC_IDX_CAP_LO, TDC_CAP_RST, "low capture reset");
      rchk(TDC_IDX_CAP_HI, TDC_CAP_RST, "high capture reset");
      apb(1'b0, 4'h3, 8'h00);
      check({31'h0, er}, 32'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      // storage bits, read-only captures, count loads
      apb(1'b1, TDC_IDX_CTL0, 8'h59);
      rchk(TDC_IDX_CTL0, 8'h59, "ctl0 storage");
      apb(1'b1, TDC_IDX_CAP_LO, 8'h55);
      apb(1'b1, TDC_IDX_CAP_HI, 8'haa);
      rchk(TDC_IDX_CAP_LO, 8'h00, "low capture write");
      rchk(TDC_IDX_CAP_HI, 8'h00, "high capture write");
      apb(1'b1, TDC_IDX_LOAD_LO, TDC_RELOAD);
      apb(1'b1, TDC_IDX_LOAD_HI, TDC_RELOAD);
      rchk(TDC_IDX_LOAD_LO, TDC_RELOAD, "load low");
      rchk(TDC_IDX_LOAD_HI, TDC_RELOAD, "load high");
      // each edge select, input route and filter in turn
      for (int i = 0; i < 6; i++) begin
         // disable first, so the rerouted pin and the new filter settle while no edge counts
         apb(1'b1, TDC_IDX_CTL0, 8'h20);
         route_p2 <= cfg[i][6];
         hi_len <= hl[i];
         lo_len <= ll[i];
         apb(1'b1, TDC_IDX_CTL1, cfg[i] | 8'h03);
         repeat (10) @(posedge pclk);
         apb(1'b1, TDC_IDX_CTL0, 8'h86);
         start <= 1'b1;
         @(posedge pclk);
         start <= 1'b0;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (busy !== 1'b0 && n < 1000);
         if (n >= 1000) begin
            failures++;
            finish_test();
         end
         // equal intervals of 128 on falling edges only put every capture on the count of zero
         if (i == 5) begin
            rchk(TDC_IDX_CTL0, 8'h86, "no timeout at capture");
         end
         // the counter reaches zero 255 cycles after its last reload
         repeat (300) @(posedge pclk);
         rchk(TDC_IDX_CAP_LO, elo[i], "low capture");
         rchk(TDC_IDX_CAP_HI, ehi[i], "high capture");
         rchk(TDC_IDX_CTL1, cfg[i] | efl[i], "edge flags");
         rchk(TDC_IDX_CTL0, (i != 4) ? 8'ha6 : 8'h86, "timeout flag");
         check({31'h0, capture_irq}, {31'h0, efl[i] != 8'h00}, "capture irq");
         check({31'h0, timeout_irq}, {31'h0, i != 4}, "timeout irq");
         if (i == 0) begin
            apb(1'b1, TDC_IDX_CTL1, cfg[i]);
            rchk(TDC_IDX_CTL1, cfg[i] | 8'h01, "flag kept");
            apb(1'b1, TDC_IDX_CTL1, cfg[i] | 8'h01);
            rchk(TDC_IDX_CTL1, cfg[i], "flag cleared");
            check({31'h0, capture_irq}, 32'h0, "capture irq cleared");
            apb(1'b1, TDC_IDX_CTL0, 8'ha6);
            rchk(TDC_IDX_CTL0, 8'h86, "timeout cleared");
         end
      end
      finish_test();
   end
endmodule
